// file: src/adc_port_regs.svh
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// Pin indices inside the synchroniser bundle
`define PIN_CS 0
`define PIN_SCLK 1
`define PIN_DIN 2
`define PIN_ACLK 3
`define PIN_COUNT 4
// Idle levels of the pins: chip select high, the rest low
`define PIN_RESET_VAL 4'h1

// Input word field positions (first bit shifted in ends at bit 7)
`define CFG_WL_LOW_BIT 0
`define CFG_WL_HIGH_BIT 1
`define CFG_MSBF_BIT 2
`define CFG_UNI_BIT 3
`define CFG_MUX_LSB 4
`define CFG_BITS 8

// Serial timing counts
`define SAMPLE_OPEN_RISE 5'd4
`define WORD_BITS_8 5'd8
`define WORD_BITS_12 5'd12
`define WORD_BITS_16 5'd16
`define WORD_BITS_SHDN 5'd10

// Conversion timing in conversion clock cycles
`define CONV_ACLK_CYCLES 6'd52
`define CS_DEGLITCH_FALLS 2'd2

// Reset values
`define RESULT_RESET 12'h000
`define CFG_RESET 8'h00

`endif

// file: src/adc_port_pkg.sv
`include "adc_port_regs.svh"

package adc_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_XFER = 3'b001,
        ST_CONV = 3'b010,
        ST_SHDN = 3'b011
    } port_state_t;

    typedef enum logic [1:0] {
        WL_8 = 2'b00,
        WL_SHDN = 2'b01,
        WL_12 = 2'b10,
        WL_16 = 2'b11
    } word_len_t;

    function automatic logic [4:0] word_bits(input word_len_t wl);
        logic [4:0] n;
        n = `WORD_BITS_8;
        unique case (wl)
            WL_8: n = `WORD_BITS_8;
            WL_SHDN: n = `WORD_BITS_SHDN;
            WL_12: n = `WORD_BITS_12;
            WL_16: n = `WORD_BITS_16;
        endcase
        return n;
    endfunction

    function automatic logic [11:0] reverse12(input logic [11:0] v);
        logic [11:0] r;
        r = 12'h000;
        for (int i = 0; i < 12; i++) begin
            r[i] = v[11 - i];
        end
        return r;
    endfunction

endpackage

// file: src/pin_edge_if.sv
`timescale 1ns/1ps
`include "adc_port_regs.svh"

interface pin_edge_if;
    logic [`PIN_COUNT-1:0] level;
    logic [`PIN_COUNT-1:0] rise;
    logic [`PIN_COUNT-1:0] fall;
    modport source (output level, output rise, output fall);
    modport sink (input level, input rise, input fall);
endinterface

// file: src/pin_sync.sv
`timescale 1ns/1ps
`include "adc_port_regs.svh"

module pin_sync (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [`PIN_COUNT-1:0] i_pins,
    pin_edge_if.source pins
);

    localparam logic [`PIN_COUNT-1:0] PIN_IDLE = `PIN_RESET_VAL;

    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
            // One register set per pin, so every stage has a single driver
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic stable_r;
            logic settled;
            // Only the second and third stages are compared; the first may be metastable
            assign settled = (s2_r == s3_r) && (s3_r != stable_r);
            always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    s1_r <= PIN_IDLE[g];
                    s2_r <= PIN_IDLE[g];
                    s3_r <= PIN_IDLE[g];
                    stable_r <= PIN_IDLE[g];
                end else begin
                    s1_r <= i_pins[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (settled) begin
                        stable_r <= s3_r;
                    end
                end
            end
            assign pins.level[g] = stable_r;
            assign pins.rise[g] = settled & s3_r;
            assign pins.fall[g] = settled & ~s3_r;
        end
    endgenerate

endmodule // pin_sync

// file: src/serial_adc_conversion_port.sv
// Summary of operation
// - Deselected port ignores every serial clock edge
// - Conversion done while selected: drive first bit
// - Sample from 4th clock to last fall
// - Window close at the last fall of a non-shutdown word: switch negative side, start converting
// - Conversion lasts 52 conversion clock cycles
// - Chip select recognised after two clock falls
// - Word length code: 8, shutdown, 12, 16
`timescale 1ns/1ps
`include "adc_port_regs.svh"

module serial_adc_conversion_port
    import adc_port_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_aclk,
    input wire logic [11:0] i_conv_code,
    output logic o_dout,
    output logic o_dout_oe_n,
    output logic o_sampling_window,
    output logic o_common_input,
    output logic o_conv_busy,
    output logic o_power_down,
    output logic [3:0] o_mux_sel,
    output logic o_unipolar
);

    pin_edge_if pins ();

    pin_sync u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_pins({i_aclk, i_din, i_sclk, i_cs_n}),
        .pins(pins.source)
    );

    port_state_t state_r;
    logic cs_rec_r;
    logic [1:0] dg_cnt_r;
    logic cs_low_evt_r;
    logic [4:0] rise_cnt_r;
    logic [4:0] fall_cnt_r;
    logic [7:0] in_sr_r;
    logic cfg_ok_r;
    word_len_t wl_r;
    logic msbf_r;
    logic [5:0] conv_cnt_r;
    logic [11:0] result_r;
    logic [15:0] out_sr_r;

    logic sel;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] in_sr_nxt;
    logic xfer_end;
    logic abort;
    logic conv_done;
    logic enter_xfer;
    logic [15:0] load_word;

    // Chip select deglitch: a change must last over two conversion clock falls
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_rec_r <= 1'b1;
            dg_cnt_r <= 2'd0;
            cs_low_evt_r <= 1'b0;
        end else begin
            cs_low_evt_r <= 1'b0;
            if (pins.level[`PIN_CS] == cs_rec_r) begin
                dg_cnt_r <= 2'd0;
            end else if (pins.fall[`PIN_ACLK]) begin
                if (dg_cnt_r == `CS_DEGLITCH_FALLS - 2'd1) begin
                    cs_rec_r <= pins.level[`PIN_CS];
                    cs_low_evt_r <= ~pins.level[`PIN_CS];
                    dg_cnt_r <= 2'd0;
                end else begin
                    dg_cnt_r <= dg_cnt_r + 2'd1;
                end
            end
        end
    end

    assign sel = ~cs_rec_r;
    // Serial clock edges count only while selected and transferring
    assign sclk_rise = sel && (state_r == ST_XFER) && pins.rise[`PIN_SCLK];
    assign sclk_fall = sel && (state_r == ST_XFER) && pins.fall[`PIN_SCLK];
    assign in_sr_nxt = {in_sr_r[6:0], pins.level[`PIN_DIN]};

    assign xfer_end = sclk_fall && cfg_ok_r
        && (5'(fall_cnt_r + 5'd1) == word_bits(wl_r));
    assign abort = (state_r == ST_XFER) && !sel;
    assign conv_done = (state_r == ST_CONV) && pins.rise[`PIN_ACLK]
        && (conv_cnt_r == `CONV_ACLK_CYCLES - 6'd1);
    assign enter_xfer = ((state_r == ST_IDLE) && sel)
        || ((state_r == ST_SHDN) && cs_low_evt_r)
        || (conv_done && sel);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (sel) begin
                        state_r <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (abort) begin
                        state_r <= ST_IDLE;
                    end else if (xfer_end) begin
                        state_r <= (wl_r == WL_SHDN) ? ST_SHDN : ST_CONV;
                    end
                end
                ST_CONV: begin
                    // Chip select is not looked at until the result is ready
                    if (conv_done) begin
                        state_r <= sel ? ST_XFER : ST_IDLE;
                    end
                end
                ST_SHDN: begin
                    if (cs_low_evt_r) begin
                        state_r <= ST_XFER;
                    end else if (sel && pins.rise[`PIN_SCLK]) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Bit counters and input word capture
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rise_cnt_r <= 5'd0;
            fall_cnt_r <= 5'd0;
            in_sr_r <= `CFG_RESET;
            cfg_ok_r <= 1'b0;
            wl_r <= WL_8;
            msbf_r <= 1'b1;
            o_mux_sel <= 4'h0;
            o_unipolar <= 1'b0;
        end else if (state_r != ST_XFER) begin
            rise_cnt_r <= 5'd0;
            fall_cnt_r <= 5'd0;
            cfg_ok_r <= 1'b0;
        end else begin
            if (sclk_rise && !cfg_ok_r) begin
                rise_cnt_r <= 5'(rise_cnt_r + 5'd1);
                in_sr_r <= in_sr_nxt;
                if (5'(rise_cnt_r + 5'd1) == 5'(`CFG_BITS)) begin
                    cfg_ok_r <= 1'b1;
                    wl_r <= word_len_t'(in_sr_nxt[`CFG_WL_HIGH_BIT:`CFG_WL_LOW_BIT]);
                    msbf_r <= in_sr_nxt[`CFG_MSBF_BIT];
                    o_unipolar <= in_sr_nxt[`CFG_UNI_BIT];
                    o_mux_sel <= in_sr_nxt[`CFG_MUX_LSB+3:`CFG_MUX_LSB];
                end
            end
            if (sclk_fall) begin
                fall_cnt_r <= 5'(fall_cnt_r + 5'd1);
            end
        end
    end

    // Sample window and hold switch to the negative side
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sampling_window <= 1'b0;
            o_common_input <= 1'b0;
            o_conv_busy <= 1'b0;
            o_power_down <= 1'b0;
        end else begin
            if (sclk_rise && (5'(rise_cnt_r + 5'd1) == `SAMPLE_OPEN_RISE)) begin
                o_sampling_window <= 1'b1;
            end else if (xfer_end || abort) begin
                o_sampling_window <= 1'b0;
            end
            if (xfer_end && (wl_r != WL_SHDN)) begin
                o_common_input <= 1'b1;
                o_conv_busy <= 1'b1;
            end else if (conv_done) begin
                o_common_input <= 1'b0;
                o_conv_busy <= 1'b0;
            end
            if (xfer_end && (wl_r == WL_SHDN)) begin
                o_power_down <= 1'b1;
            end else if (state_r != ST_SHDN) begin
                o_power_down <= 1'b0;
            end
        end
    end

    // Conversion sequencer, timed by the conversion clock
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            conv_cnt_r <= 6'd0;
            result_r <= `RESULT_RESET;
        end else if (state_r != ST_CONV) begin
            conv_cnt_r <= 6'd0;
        end else if (pins.rise[`PIN_ACLK]) begin
            conv_cnt_r <= 6'(conv_cnt_r + 6'd1);
            if (conv_done) begin
                result_r <= i_conv_code;
            end
        end
    end

    // The code is ready in the same cycle the conversion ends
    assign load_word = msbf_r
        ? {(conv_done ? i_conv_code : result_r), 4'h0}
        : {reverse12(conv_done ? i_conv_code : result_r), 4'h0};

    // Output shifter; the bus is released whenever no transfer is under way
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_sr_r <= 16'h0000;
            o_dout <= 1'b0;
            o_dout_oe_n <= 1'b1;
        end else if (enter_xfer) begin
            out_sr_r <= load_word;
            o_dout <= load_word[15];
            o_dout_oe_n <= 1'b0;
        end else if (sclk_fall && !xfer_end) begin
            out_sr_r <= {out_sr_r[14:0], 1'b0};
            o_dout <= out_sr_r[14];
        end else if (state_r != ST_XFER || xfer_end || abort) begin
            o_dout <= 1'b0;
            o_dout_oe_n <= 1'b1;
        end
    end

endmodule // serial_adc_conversion_port

// file: testbench/adc_port_props.sv
`timescale 1ns/1ps
module adc_port_props (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_aclk,
    input wire logic o_dout_oe_n,
    input wire logic o_sampling_window,
    input wire logic o_common_input,
    input wire logic o_conv_busy,
    input wire logic o_power_down,
    input wire logic [3:0] o_mux_sel
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Saturating, so long idle spans never wrap back below the threshold
    logic [9:0] hi_r;
    logic [11:0] lo_r;
    logic [6:0] rises_r;
    logic aclk_r;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hi_r <= 10'h000;
            lo_r <= 12'h000;
        end else begin
            hi_r <= i_cs_n ? hi_r + {9'h000, ~&hi_r} : 10'h000;
            lo_r <= i_cs_n ? 12'h000 : lo_r + {11'h000, ~&lo_r};
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aclk_r <= 1'b0;
            rises_r <= 7'h00;
        end else begin
            aclk_r <= i_aclk;
            rises_r <= o_conv_busy ? rises_r + {6'h00, i_aclk & ~aclk_r} : 7'h00;
        end
    end
    chk_desel_quiet: assert property (hi_r > 10'd200 |=> $stable(o_mux_sel) && o_dout_oe_n)
        else $error("port active while deselected");
    chk_busy_released: assert property (o_conv_busy |-> o_dout_oe_n)
        else $error("output driven during conversion");
    chk_window_start: assert property ($rose(o_conv_busy) |-> $fell(o_sampling_window))
        else $error("conversion began without window close");
    chk_common_side: assert property (o_conv_busy == o_common_input)
        else $error("negative side not held during conversion");
    chk_conv_length: assert property ($fell(o_conv_busy) |-> rises_r inside {[51:53]})
        else $error("conversion length wrong");
    chk_window_open: assert property ($rose(o_sampling_window) |-> !o_dout_oe_n && !i_cs_n)
        else $error("window opened outside a transfer");
    chk_low_cs_drive: assert property ($fell(o_conv_busy) && lo_r > 12'd300 |-> ##[0:3] !o_dout_oe_n)
        else $error("output not driven after conversion");
    chk_shutdown_idle: assert property (o_power_down |-> !o_conv_busy && !o_sampling_window)
        else $error("activity in shutdown");
    cover property ($rose(o_conv_busy));
    cover property ($rose(o_power_down));
    cover property ($fell(o_conv_busy) && lo_r > 12'd300);
endmodule // adc_port_props

// file: testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire logic i_clk_sys,
    input wire logic i_dout,
    input wire logic i_dout_oe_n,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din,
    output logic o_aclk
);
    int div_r = 0;
    initial o_cs_n = 1'b1;
    initial o_sclk = 1'b0;
    initial o_din = 1'b0;
    initial o_aclk = 1'b0;
    // Conversion clock at 2 MHz, the top rate; serial clock 160 ns, in frames and also spun while deselected
    always @(posedge i_clk_sys) begin
        div_r <= (div_r == 24) ? 0 : div_r + 1;
        if (div_r == 24) o_aclk <= ~o_aclk;
    end
    task automatic pulse(input logic bit_in, output logic seen);
        o_din <= bit_in;
        repeat (8) @(posedge i_clk_sys);
        o_sclk <= 1'b1;
        @(negedge i_clk_sys);
        // No pull on the line: a released output reads as the wrong level
        seen = i_dout_oe_n ? ~i_dout : i_dout;
        repeat (8) @(posedge i_clk_sys);
        o_sclk <= 1'b0;
    endtask
    task automatic spin(input int n);
        logic b;
        for (int i = 0; i < n; i++) pulse(1'b1, b);
    endtask
    // Sends one word whose clock count matches its length code
    task automatic xfer(input logic [7:0] cfg, input int n, input logic hold,
                        output logic [15:0] got, output logic ok);
        int k;
        logic b;
        got = 16'h0000;
        k = 0;
        o_cs_n <= 1'b0;
        while (i_dout_oe_n !== 1'b0 && k < 400) begin
            @(negedge i_clk_sys);
            k++;
        end
        ok = (k < 400);
        @(posedge i_clk_sys);
        for (int i = 0; i < n; i++) begin
            pulse((i < 8) ? cfg[7 - i] : 1'b0, b);
            got = {got[14:0], b};
        end
        repeat (8) @(posedge i_clk_sys);
        if (!hold) o_cs_n <= 1'b1;
    endtask
endmodule // host_model

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [11:0] CODE = 12'ha5c;
    logic i_clk_sys, i_rst_n, cs_n, sclk, din, aclk, dout, oe_n, win, common_input, busy, pdn, uni;
    logic [3:0] mux;
    logic [15:0] got;
    logic ok;
    int miscompares = 0;
    int total_checks = 0;
    host_model host (.i_clk_sys(i_clk_sys), .i_dout(dout), .i_dout_oe_n(oe_n), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_din(din), .o_aclk(aclk));
    serial_adc_conversion_port dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_din(din), .i_aclk(aclk), .i_conv_code(CODE), .o_dout(dout),
        .o_dout_oe_n(oe_n), .o_sampling_window(win), .o_common_input(common_input),
        .o_conv_busy(busy), .o_power_down(pdn), .o_mux_sel(mux), .o_unipolar(uni));
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_word(input string name, input logic [7:0] cfg, input int n,
                          input logic hold, input logic [15:0] exp);
        host.xfer(cfg, n, hold, got, ok);
        @(negedge i_clk_sys);
        cmp({name, " select"}, 16'h0001, {15'h0000, ok});
        cmp({name, " data"}, exp, got);
        cmp({name, " mode"}, {11'h000, cfg[3], cfg[7:4]}, {11'h000, uni, mux});
        cmp({name, " busy"}, {15'h0000, cfg[1:0] != 2'b01}, {15'h0000, busy});
        // Full cycle spacing also outlasts the conversion
        if (!hold) repeat (4000) @(posedge i_clk_sys);
        cmp({name, " power"}, {15'h0000, cfg[1:0] == 2'b01}, {15'h0000, pdn});
        $display("test %s done", name);
    endtask
    task automatic t_desel();
        host.spin(12);
        @(negedge i_clk_sys);
        cmp("deselected", 16'h0025, {10'h000, oe_n, win, mux});
        @(posedge i_clk_sys);
        $display("test deselect done");
    endtask
    task automatic t_cs_low();
        int k;
        k = 0;
        while (oe_n !== 1'b0 && k < 3500) begin
            @(negedge i_clk_sys);
            k++;
        end
        cmp("low cs wait", 16'h0001, {15'h0000, k < 3500});
        cmp("low cs first bit", {15'h0000, CODE[11]}, {15'h0000, dout});
        cmp("low cs busy", 16'h0000, {15'h0000, busy});
        @(posedge i_clk_sys);
        $display("test low select done");
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        repeat (40000) @(posedge i_clk_sys);
        miscompares++;
        $display("BAD watchdog expected finish seen hang");
        final_report();
    end
    task automatic t_reset();
        repeat (5) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        cmp("reset", 16'h0400, {4'h0, dout, oe_n, win, common_input, busy, pdn, uni, 1'b0, mux});
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        $display("test reset done");
    endtask
    initial begin
        i_rst_n = 1'b0;
        t_reset();
        t_word("w12", 8'h3e, 12, 1'b0, 16'h0000);
        t_word("w16", 8'ha3, 16, 1'b0, {CODE, 4'h0});
        // Bit-reversed CODE is 12'h3a5, first eight bits only
        t_word("w8", 8'h5c, 8, 1'b0, 16'h003a);
        t_desel();
        t_word("w12hold", 8'h06, 12, 1'b1, {4'h0, CODE});
        t_cs_low();
        t_word("shdn", 8'h01, 10, 1'b0, {6'h00, CODE[11:2]});
        // Chip select fall wakes the port; the shutdown word asked for LSB first
        t_word("wake", 8'h3e, 12, 1'b0, 16'h03a5);
        final_report();
    end
endmodule // tb
bind serial_adc_conversion_port adc_port_props chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n), .i_aclk(i_aclk), .o_dout_oe_n(o_dout_oe_n),
    .o_sampling_window(o_sampling_window), .o_common_input(o_common_input),
    .o_conv_busy(o_conv_busy), .o_power_down(o_power_down), .o_mux_sel(o_mux_sel));
